// [rtl/ftc_reg_bank.sv]
// Transaction configuration register bank with APB slave and erase/program/map helpers
`timescale 1ns/100ps
`default_nettype none
module ftc_reg_bank
    import ftc_pkg::*;
(
    input  wire logic                  pclk,              // APB clock, 50 MHz
    input  wire logic                  presetn,           // Async reset, active low
    input  wire logic                  psel,              // APB select
    input  wire logic                  penable,           // APB enable
    input  wire logic                  pwrite,            // APB direction
    input  wire logic [7:0]            paddr,             // APB byte address
    input  wire logic [31:0]           pwdata,            // APB write data
    output logic      [31:0]           prdata,            // APB read data
    output logic                       pready,            // APB ready
    output logic                       pslverr,           // APB error, unmapped address
    input  wire logic                  sclk,              // Serial link clock pin
    input  wire logic                  rd_lat_start,      // Register read enters latency phase
    output logic                       rd_lat_done,       // Dummy cycles complete, pulse
    input  wire logic                  erase_req,         // Erase transaction request, pulse
    input  wire logic                  erase_small,       // Request is small-sector erase 20h
    input  wire logic                  sector_blank,      // Target sector evaluated blank
    output ftc_erase_s                 erase_out,         // Erase start/abort/ignored pulses
    input  wire logic                  prog_start,        // Page program begins, pulse
    input  wire logic [8:0]            prog_col,          // Start column of page program
    input  wire logic                  prog_byte,         // One data byte accepted, pulse
    output logic      [8:0]            buf_index,         // Buffer slot of next byte
    input  wire logic [FTC_ADDR_W-1:0] array_addr,        // Array address under decode
    output logic                       small_sector_hit,  // Address lies in small-sector block
    output ftc_cfg_s                   cfg                // Live configuration (volatile copy)
);

    // Register file and APB state
    logic [7:0]  nonvol_r, nonvol_nxt;
    ftc_cfg_s    vol_r, vol_nxt;
    logic        topsel_r, topsel_nxt;
    logic        load_r, load_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic        pready_r, pready_nxt;
    logic        pslverr_r, pslverr_nxt;

    // Engine state
    logic        sclk_meta_r, sclk_sync_r, sclk_prev_r;
    ftc_lat_e    lat_st_r, lat_st_nxt;
    logic [1:0]  lat_cnt_r, lat_cnt_nxt;
    logic        lat_done_r, lat_done_nxt;
    ftc_erase_s  erase_r, erase_nxt;
    logic [8:0]  idx_r, idx_nxt;
    logic        hit_r, hit_nxt;

    logic        acc, wr, mapped;
    logic [8:0]  buf_mask;
    logic        sclk_rise;

    assign acc       = psel & penable & pready_r;
    assign wr        = acc & pwrite;
    assign sclk_rise = sclk_sync_r & ~sclk_prev_r;
    assign buf_mask  = vol_r.program_buffer_size_sel ? FTC_BUF512_MASK : FTC_BUF256_MASK;

    // Registers and bus slave; one wait state on every access
    always_comb begin
        nonvol_nxt  = nonvol_r;
        vol_nxt     = vol_r;
        topsel_nxt  = topsel_r;
        load_nxt    = 1'b0;
        prdata_nxt  = prdata_r;
        pslverr_nxt = 1'b0;
        pready_nxt  = psel & penable & ~pready_r;
        mapped      = (paddr == FTC_OFS_NONVOL) || (paddr == FTC_OFS_VOL) ||
                      (paddr == FTC_OFS_CTRL) || (paddr == FTC_OFS_STATUS);
        if (psel && penable && !pready_r) begin
            pslverr_nxt = ~mapped;
            unique case (paddr)
                FTC_OFS_NONVOL: prdata_nxt = {24'h000000, nonvol_r};
                FTC_OFS_VOL:    prdata_nxt = {24'h000000, vol_r};
                FTC_OFS_CTRL:   prdata_nxt = {30'h00000000, topsel_r, 1'b0};
                FTC_OFS_STATUS: prdata_nxt = {20'h00000, lat_cnt_r, lat_st_r == FTC_LAT_COUNT, idx_r};
                default:        prdata_nxt = 32'h00000000;
            endcase
        end
        if (wr) begin
            unique case (paddr)
                FTC_OFS_NONVOL: nonvol_nxt = pwdata[7:0];
                FTC_OFS_VOL: begin
                    // Sector map is read-only in the volatile copy
                    vol_nxt = ftc_cfg_s'(pwdata[7:0]);
                    vol_nxt.sector_map_hybrid_sel = vol_r.sector_map_hybrid_sel;
                end
                FTC_OFS_CTRL: begin
                    topsel_nxt = pwdata[FTC_CTRL_TOPSEL];
                    load_nxt   = pwdata[FTC_CTRL_RELOAD];
                end
                default: ;
            endcase
        end
        // Copy taken one edge after reset release or on reload request
        if (load_r) begin
            vol_nxt = ftc_cfg_s'(nonvol_r);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nonvol_r  <= FTC_NONVOL_RST;
            vol_r     <= ftc_cfg_s'(FTC_VOL_RST);
            topsel_r  <= FTC_CTRL_RST[FTC_CTRL_TOPSEL];
            load_r    <= 1'b1;
            prdata_r  <= 32'h00000000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            nonvol_r  <= nonvol_nxt;
            vol_r     <= vol_nxt;
            topsel_r  <= topsel_nxt;
            load_r    <= load_nxt;
            prdata_r  <= prdata_nxt;
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // Latency, erase, program wrap and address map
    always_comb begin
        lat_st_nxt   = lat_st_r;
        lat_cnt_nxt  = lat_cnt_r;
        lat_done_nxt = 1'b0;
        unique case (lat_st_r)
            FTC_LAT_IDLE: begin
                if (rd_lat_start) begin
                    if (vol_r.reg_read_latency_sel == 2'h0) begin
                        lat_done_nxt = 1'b1;
                    end else begin
                        lat_cnt_nxt = vol_r.reg_read_latency_sel;
                        lat_st_nxt  = FTC_LAT_COUNT;
                    end
                end
            end
            FTC_LAT_COUNT: begin
                if (sclk_rise) begin
                    lat_cnt_nxt = lat_cnt_r - 2'h1;
                    if (lat_cnt_r == 2'h1) begin
                        lat_done_nxt = 1'b1;
                        lat_st_nxt   = FTC_LAT_IDLE;
                    end
                end
            end
        endcase

        erase_nxt = '0;
        if (erase_req) begin
            if (erase_small && !vol_r.sector_map_hybrid_sel) begin
                erase_nxt.ignored = 1'b1;
            end else if (vol_r.erase_blank_check_en && sector_blank) begin
                erase_nxt.abort = 1'b1;
            end else begin
                erase_nxt.start = 1'b1;
            end
        end

        // Masking keeps the index inside the selected buffer
        // Shrinking the buffer folds a stale index back inside it
        idx_nxt = idx_r & buf_mask;
        if (prog_start) begin
            idx_nxt = prog_col & buf_mask;
        end else if (prog_byte) begin
            idx_nxt = 9'((idx_r + 9'h001) & buf_mask);
        end

        // Small block only exists in the hybrid map
        hit_nxt = vol_r.sector_map_hybrid_sel &&
                  (array_addr[FTC_ADDR_W-1 -: FTC_SMALL_HI_W] == (topsel_r ? FTC_SMALL_TOP : FTC_SMALL_BOT));
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_meta_r <= 1'b0;
            sclk_sync_r <= 1'b0;
            sclk_prev_r <= 1'b0;
            lat_st_r    <= FTC_LAT_IDLE;
            lat_cnt_r   <= 2'h0;
            lat_done_r  <= 1'b0;
            erase_r     <= '0;
            idx_r       <= 9'h000;
            hit_r       <= 1'b0;
        end else begin
            sclk_meta_r <= sclk;
            sclk_sync_r <= sclk_meta_r;
            sclk_prev_r <= sclk_sync_r;
            lat_st_r    <= lat_st_nxt;
            lat_cnt_r   <= lat_cnt_nxt;
            lat_done_r  <= lat_done_nxt;
            erase_r     <= erase_nxt;
            idx_r       <= idx_nxt;
            hit_r       <= hit_nxt;
        end
    end

    assign prdata           = prdata_r;
    assign pready           = pready_r;
    assign pslverr          = pslverr_r;
    assign rd_lat_done      = lat_done_r;
    assign erase_out        = erase_r;
    assign buf_index        = idx_r;
    assign small_sector_hit = hit_r;
    assign cfg              = vol_r;

    // Checks
    sequence zero_lat_req;
        rd_lat_start && lat_st_r == FTC_LAT_IDLE && vol_r.reg_read_latency_sel == 2'h0;
    endsequence
    sequence blank_abort_req;
        erase_req && !erase_small && vol_r.erase_blank_check_en && sector_blank;
    endsequence

    zero_latency_a: assert property (@(posedge pclk) disable iff (!presetn)
        zero_lat_req |=> rd_lat_done) else $error("zero latency read not done next cycle");
    latency_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
        lat_st_r == FTC_LAT_COUNT && lat_cnt_r == 2'h1 && sclk_rise |=> rd_lat_done && lat_st_r == FTC_LAT_IDLE)
        else $error("latency count did not finish on last edge");
    blank_abort_a: assert property (@(posedge pclk) disable iff (!presetn)
        blank_abort_req |=> erase_out.abort && !erase_out.start) else $error("blank sector erase not aborted");
    erase_uncond_a: assert property (@(posedge pclk) disable iff (!presetn)
        erase_req && !erase_small && !vol_r.erase_blank_check_en |=> erase_out.start)
        else $error("erase not started with blank check off");
    buf_size_a: assert property (@(posedge pclk) disable iff (!presetn)
        !vol_r.program_buffer_size_sel && !$past(vol_r.program_buffer_size_sel) |-> !buf_index[8])
        else $error("index past 256 byte buffer");
    buf_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
        prog_byte && !prog_start && (idx_r | ~buf_mask) == 9'h1ff && $stable(buf_mask) |=> buf_index == 9'h000)
        else $error("buffer index did not wrap");
    uniform_map_a: assert property (@(posedge pclk) disable iff (!presetn)
        !vol_r.sector_map_hybrid_sel [*2] |-> !small_sector_hit) else $error("small sector hit in uniform map");
    small_ignore_a: assert property (@(posedge pclk) disable iff (!presetn)
        erase_req && erase_small && !vol_r.sector_map_hybrid_sel |=> erase_out.ignored && !erase_out.start)
        else $error("small sector erase not ignored in uniform map");
    reset_load_a: assert property (@(posedge pclk) disable iff (!presetn)
        load_r |=> vol_r == ftc_cfg_s'($past(nonvol_r))) else $error("volatile copy not loaded");
    hybrid_top_a: assert property (@(posedge pclk) disable iff (!presetn)
        vol_r.sector_map_hybrid_sel && topsel_r && array_addr[FTC_ADDR_W-1 -: FTC_SMALL_HI_W] == FTC_SMALL_TOP
        && $stable(vol_r) |=> small_sector_hit) else $error("top overlay not decoded");

endmodule
`default_nettype wire

// [shared/ftc_pkg.sv]
// Package of constants and types for the transaction configuration register bank
package ftc_pkg;

    // Register byte addresses
    localparam logic [7:0] FTC_OFS_NONVOL = 8'h00;
    localparam logic [7:0] FTC_OFS_VOL    = 8'h04;
    localparam logic [7:0] FTC_OFS_CTRL   = 8'h08;
    localparam logic [7:0] FTC_OFS_STATUS = 8'h0c;

    // Factory defaults
    localparam logic [7:0] FTC_NONVOL_RST = 8'h00;
    localparam logic [7:0] FTC_VOL_RST    = 8'h00;
    localparam logic [1:0] FTC_CTRL_RST   = 2'h0;

    // Field positions of the configuration byte
    localparam int FTC_LAT_LSB    = 6;
    localparam int FTC_BLANK_BIT  = 5;
    localparam int FTC_BUF_BIT    = 4;
    localparam int FTC_HYBRID_BIT = 3;

    // Control register bits
    localparam int FTC_CTRL_RELOAD = 0;
    localparam int FTC_CTRL_TOPSEL = 1;

    // Program buffer index masks: 256 and 512 bytes
    localparam logic [8:0] FTC_BUF256_MASK = 9'h0ff;
    localparam logic [8:0] FTC_BUF512_MASK = 9'h1ff;

    // Array address width and small-sector block span (32 x 4KB)
    localparam int          FTC_ADDR_W      = 26;
    localparam int          FTC_SMALL_HI_W  = 9;
    localparam logic [8:0]  FTC_SMALL_TOP   = 9'h1ff;
    localparam logic [8:0]  FTC_SMALL_BOT   = 9'h000;

    typedef struct packed {
        logic [1:0] reg_read_latency_sel;
        logic       erase_blank_check_en;
        logic       program_buffer_size_sel;
        logic       sector_map_hybrid_sel;
        logic       opcode30_function_sel;
        logic       reserved_bit;
        logic       legacy_reset_sel;
    } ftc_cfg_s;

    typedef struct packed {
        logic       start;
        logic       abort;
        logic       ignored;
    } ftc_erase_s;

    typedef enum logic {FTC_LAT_IDLE, FTC_LAT_COUNT} ftc_lat_e;

endpackage

// [tb/ftc_host_model.sv]
// Host-side serial clock source for the configuration register bench
`timescale 1ns/100ps
`default_nettype none
module ftc_host_model (
    input  wire logic run,  // Frame in progress
    output logic      sclk  // Serial clock, 160 ns period
);
    // Odd start offset keeps the link phase unrelated to pclk
    initial begin
        sclk = 1'b0;
        #3.7;
        forever #80 sclk = run ? ~sclk : 1'b0;
    end
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench for the transaction configuration register bank
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import ftc_pkg::*;
    logic                  pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]            paddr = 0;
    logic [31:0]           pwdata = 0, prdata, v, rd;
    logic                  pready, pslverr, er, sclk, run_sclk = 0, rd_lat_done, small_sector_hit;
    logic                  rd_lat_start = 0, erase_req = 0, erase_small = 0, sector_blank = 0;
    logic                  prog_start = 0, prog_byte = 0;
    logic [8:0]            prog_col = 0, buf_index;
    logic [FTC_ADDR_W-1:0] array_addr = 0;
    ftc_erase_s            erase_out;
    ftc_cfg_s              cfg;
    int                    seed = 93, n_mismatch = 0, samples_checked = 0, e, n, k, rises = 0;
    int                    exp_q[$];

    always #10 pclk = ~pclk;
    always @(posedge sclk) rises++;

    ftc_host_model host_u (.run(run_sclk), .sclk(sclk));

    ftc_reg_bank dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclk(sclk),
        .rd_lat_start(rd_lat_start), .rd_lat_done(rd_lat_done), .erase_req(erase_req),
        .erase_small(erase_small), .sector_blank(sector_blank), .erase_out(erase_out),
        .prog_start(prog_start), .prog_col(prog_col), .prog_byte(prog_byte), .buf_index(buf_index),
        .array_addr(array_addr), .small_sector_hit(small_sector_hit), .cfg(cfg));

    task chk(input logic [31:0] s, input logic [31:0] x);
        samples_checked++;
        if (s !== x) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask

    // Entered just after a rising edge; holds the request until pready is seen at an edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) n_mismatch++;
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        // Idle edge so a following call never reassigns psel in this time step
        @(posedge pclk);
    endtask

    task setcfg(input logic [7:0] c, input logic t);
        apb(1, FTC_OFS_NONVOL, {24'h0, c});
        apb(1, FTC_OFS_CTRL, {30'h0, t, 1'b1});
        repeat (2) @(posedge pclk);
        chk({24'h0, cfg}, {24'h0, c});
    endtask

    task final_report();
        $display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        #600000;
        n_mismatch++;
        final_report();
    end

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        apb(0, FTC_OFS_NONVOL, 0);
        chk(rd, {24'h0, FTC_NONVOL_RST});
        apb(0, FTC_OFS_VOL, 0);
        chk(rd, {24'h0, FTC_VOL_RST});
        chk({24'h0, cfg}, 0);
        v = $random(seed);
        apb(1, FTC_OFS_NONVOL, v);
        apb(0, FTC_OFS_NONVOL, 0);
        chk(rd, {24'h0, v[7:0]});
        apb(1, FTC_OFS_VOL, 32'hff);
        apb(0, FTC_OFS_VOL, 0);
        chk(rd, 32'hf7);
        apb(0, 8'h10, 0);
        chk({31'h0, er}, 1);
        $display("test registers done");
        for (int b = 0; b < 2; b++) begin
            for (int h = 0; h < 2; h++) begin
                v = $random(seed);
                v[5] = b[0];
                v[3] = h[0];
                setcfg(v[7:0], 1'b0);
                for (int s = 0; s < 4; s++) begin
                    erase_req <= 1;
                    erase_small <= s[1];
                    sector_blank <= s[0];
                    @(posedge pclk);
                    erase_req <= 0;
                    exp_q.push_back((s[1] && h == 0) ? 1 : (b == 1 && s[0]) ? 2 : 4);
                    @(negedge pclk);
                    chk({29'h0, erase_out}, exp_q.pop_front());
                    @(posedge pclk);
                end
            end
        end
        $display("test erase done");
        for (int p = 0; p < 2; p++) begin
            setcfg({3'h0, p[0], 4'h0}, 1'b0);
            v = $random(seed);
            n = v[31:22] % 600;
            prog_col <= v[8:0];
            prog_start <= 1;
            @(posedge pclk);
            prog_start <= 0;
            prog_byte <= (n != 0);
            repeat (n) @(posedge pclk);
            if (n != 0) prog_byte <= 0;
            @(negedge pclk);
            e = (v[8:0] + n) % (p ? 512 : 256);
            chk({23'h0, buf_index}, e);
            @(posedge pclk);
            apb(0, FTC_OFS_STATUS, 0);
            chk(rd & 32'h1ff, e);
        end
        $display("test program buffer done");
        for (int h = 0; h < 2; h++) begin
            for (int t = 0; t < 2; t++) begin
                setcfg({4'h0, h[0], 3'h0}, t[0]);
                for (int m = 0; m < 2; m++) begin
                    v = $random(seed);
                    array_addr <= {(t ? 9'h1ff : 9'h000) ^ {9{m[0]}}, v[16:0]};
                    @(posedge pclk);
                    @(negedge pclk);
                    chk({31'h0, small_sector_hit}, (h == 1 && m == 0));
                    @(posedge pclk);
                end
            end
        end
        $display("test sector map done");
        for (int l = 0; l < 4; l++) begin
            setcfg({l[1:0], 6'h0}, 1'b0);
            rises = 0;
            rd_lat_start <= 1;
            @(posedge pclk);
            rd_lat_start <= 0;
            run_sclk <= 1;
            k = 0;
            do begin
                @(negedge pclk);
                k++;
            end while (rd_lat_done !== 1'b1 && k < 300);
            if (k >= 300) n_mismatch++;
            chk(rises, l);
            @(posedge pclk);
            run_sclk <= 0;
        end
        $display("test latency done");
        final_report();
    end
endmodule
`default_nettype wire
